// File: common/lcd_seg_pkg.sv
// Overview of operation
// [RULE_01] New bits shift into the register only while the active-low chip select is low; the code also shifts on any select change with the clock high.
// [RULE_02] The serial data input is sampled into the register on each falling edge of the serial clock.
// [RULE_03] The serial data output takes the bit leaving the register on each rising edge of the serial clock.
// [RULE_04] The segment latch follows the register while load is high and holds when load is low.
// [RULE_05] A host deferring the latch parks the clock low before it deselects the device.
// [RULE_06] Chip select changing while the clock is high makes one extra shift.
// [RULE_07] A latched one drives its segment in antiphase with the backplane, a zero leaves it off.
// [RULE_08] Devices chain serial output to serial input with load, clock and chip select shared.
// [RULE_09] With the internal oscillator the backplane is the oscillator divided by 256.
// [RULE_10] With an external clock each clock cycle resets the divider so the backplane follows that clock.
// [RULE_11] With the oscillator pin tied high the oscillator stops and the outputs are static levels.
// [RULE_12] Shift register and latch are 30 bits, the serial output carries the last stage.
// [RULE_13] The backplane is an even square wave, off segments follow it and on segments invert it.
package lcd_seg_pkg;
    localparam int SEG_COUNT = 30;
    localparam int BP_DIVIDE = 256;
    localparam int DIV_WIDTH = 8;
    localparam int BP_HALF = BP_DIVIDE / 2;
    localparam logic [DIV_WIDTH-1:0] DIV_HALF_LAST = DIV_WIDTH'(BP_HALF - 1);
    localparam logic [DIV_WIDTH-1:0] DIV_RESET = 8'h00;
    localparam logic [SEG_COUNT-1:0] SEG_RESET = 30'h0000_0000;
    localparam int FIFO_WIDTH = 1;
    localparam int FIFO_DEPTH = 4;
    // cycles of osc pin held high before the oscillator counts as stopped
    localparam logic [DIV_WIDTH:0] STOP_CYCLES = 9'h100;
    typedef enum logic [1:0] {
        BP_INTERNAL = 2'b00,
        BP_EXTERNAL = 2'b01,
        BP_STATIC = 2'b11
    } bp_mode_t;
endpackage : lcd_seg_pkg

// File: design/bit_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module bit_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    // handshakes gated by honest full and empty
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    // storage, no reset needed for data
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : bit_fifo
`default_nettype wire

// File: design/lcd_seg_driver.sv
`timescale 1ns/10ps
`default_nettype none
module lcd_seg_driver (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // serial load port, all asynchronous pins
    input wire logic chip_sel_n,
    input wire logic ser_clk,
    input wire logic ser_load,
    input wire logic ser_din,
    output logic ser_dout,
    // oscillator pins
    input wire logic osc_clock_pin,
    input wire logic osc_option_pin,
    // display outputs
    output logic [lcd_seg_pkg::SEG_COUNT-1:0] segment,
    output logic backplane
);
    // two-stage synchronisers, first stage read only by the second
    logic [5:0] sync_a;
    logic [5:0] sync_b;
    logic opt_s;
    logic cs_n_s;
    logic clk_s;
    logic load_s;
    logic din_s;
    logic osc_s;
    logic clk_q;
    logic cs_q;
    logic osc_q;
    logic din_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            // select idles high, strap idles at internal, so no false edge or mode after reset
            sync_a <= 6'h21;
            sync_b <= 6'h21;
        end else begin
            sync_a <= {osc_option_pin, osc_clock_pin, ser_din, ser_load, ser_clk, chip_sel_n};
            sync_b <= sync_a;
        end
    end
    assign cs_n_s = sync_b[0];
    assign clk_s = sync_b[1];
    assign load_s = sync_b[2];
    assign din_s = sync_b[3];
    assign osc_s = sync_b[4];
    // the strap is a pin too, so it passes the same two flops
    assign opt_s = sync_b[5];

    // previous values for edge detection
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_q <= 1'b0;
            cs_q <= 1'b1;
            osc_q <= 1'b0;
            din_q <= 1'b0;
        end else begin
            clk_q <= clk_s;
            cs_q <= cs_n_s;
            osc_q <= osc_s;
            din_q <= din_s;
        end
    end

    logic clk_fall;
    logic clk_rise;
    logic cs_toggle_high;
    logic shift_now;
    // [RULE_02] falling edge samples
    assign clk_fall = clk_q && !clk_s;
    assign clk_rise = !clk_q && clk_s;
    // [RULE_06] extra shift pulse
    assign cs_toggle_high = (cs_q != cs_n_s) && clk_s;
    // [RULE_01] only while selected; the spurious pulse shifts regardless
    assign shift_now = (clk_fall && !cs_n_s) || cs_toggle_high;

    // incoming bits pass a small fifo so a shift never races the register
    logic fifo_in_ready;
    logic fifo_valid;
    logic [lcd_seg_pkg::FIFO_WIDTH-1:0] fifo_bit;
    logic take_bit;

    bit_fifo #(
        .WIDTH(lcd_seg_pkg::FIFO_WIDTH),
        .DEPTH(lcd_seg_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(shift_now),
        .in_ready(fifo_in_ready),
        .in_data(din_q),
        .out_valid(fifo_valid),
        .out_ready(take_bit),
        .out_data(fifo_bit)
    );

    // register drains one bit per cycle; stalls while a rising edge is being handled
    assign take_bit = fifo_valid && !clk_rise;

    // [RULE_12] 30-bit shift register
    logic [lcd_seg_pkg::SEG_COUNT-1:0] shift_reg;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= lcd_seg_pkg::SEG_RESET;
        end else if (take_bit) begin
            shift_reg <= {shift_reg[lcd_seg_pkg::SEG_COUNT-2:0], fifo_bit[0]};
        end
    end

    // [RULE_03] output updates on rising edge, chain ready per RULE_08
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ser_dout <= 1'b0;
        end else if (clk_rise) begin
            // [RULE_08] last stage feeds next device
            ser_dout <= shift_reg[lcd_seg_pkg::SEG_COUNT-1];
        end
    end

    // [RULE_04] transparent latch while load high
    logic [lcd_seg_pkg::SEG_COUNT-1:0] seg_latch;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            seg_latch <= lcd_seg_pkg::SEG_RESET;
        end else if (load_s) begin
            seg_latch <= shift_reg;
        end
    end

    // oscillator mode: option pin high selects internal, low selects external
    lcd_seg_pkg::bp_mode_t mode;
    logic [lcd_seg_pkg::DIV_WIDTH:0] high_run;
    logic osc_rise;
    assign osc_rise = !osc_q && osc_s;

    // count cycles the osc pin sits high to spot a tie to supply
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            high_run <= '0;
        end else if (!osc_s) begin
            high_run <= '0;
        end else if (high_run != lcd_seg_pkg::STOP_CYCLES) begin
            high_run <= high_run + 1'b1;
        end
    end

    // mode chosen from high_run and the option strap, refreshed every cycle after reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= lcd_seg_pkg::BP_INTERNAL;
        end else if (high_run == lcd_seg_pkg::STOP_CYCLES) begin
            // [RULE_11] oscillator stopped
            mode <= lcd_seg_pkg::BP_STATIC;
        end else if (opt_s) begin
            mode <= lcd_seg_pkg::BP_INTERNAL;
        end else begin
            mode <= lcd_seg_pkg::BP_EXTERNAL;
        end
    end

    // backplane divider; one toggle every half period of 128 osc cycles
    logic [lcd_seg_pkg::DIV_WIDTH-1:0] div_cnt;
    logic bp;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= lcd_seg_pkg::DIV_RESET;
            bp <= 1'b0;
        end else begin
            case (mode)
                lcd_seg_pkg::BP_INTERNAL: begin
                    // [RULE_09] divide by 256, even duty per RULE_13
                    if (osc_rise) begin
                        if (div_cnt == lcd_seg_pkg::DIV_HALF_LAST) begin
                            div_cnt <= lcd_seg_pkg::DIV_RESET;
                            bp <= !bp;
                        end else begin
                            div_cnt <= div_cnt + 1'b1;
                        end
                    end
                end
                lcd_seg_pkg::BP_EXTERNAL: begin
                    // [RULE_10] each cycle resets divider; backplane follows clock
                    div_cnt <= lcd_seg_pkg::DIV_RESET;
                    bp <= osc_s;
                end
                lcd_seg_pkg::BP_STATIC: begin
                    // [RULE_11] static dc backplane
                    div_cnt <= lcd_seg_pkg::DIV_RESET;
                    bp <= 1'b0;
                end
                default: begin
                    div_cnt <= lcd_seg_pkg::DIV_RESET;
                    bp <= 1'b0;
                end
            endcase
        end
    end

    // [RULE_07] antiphase drive for ones
    // [RULE_13] off follows backplane
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            segment <= lcd_seg_pkg::SEG_RESET;
            backplane <= 1'b0;
        end else begin
            segment <= seg_latch ^ {lcd_seg_pkg::SEG_COUNT{bp}};
            backplane <= bp;
        end
    end

    // fifo overflow is impossible at legal serial rates; in_ready left for observation only
    logic unused_ready;
    assign unused_ready = fifo_in_ready;
endmodule : lcd_seg_driver
`default_nettype wire

// File: test/lcd_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module lcd_host_model (
    // clock
    input wire logic sys_clk,
    // serial load port
    output logic chip_sel_n = 1'b1,
    output logic ser_clk = 1'b0,
    output logic ser_load = 1'b0,
    output logic ser_din = 1'b0
);
    // callers sit just after a rising edge
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : wt
    // one frame msb first; select settles before the clock moves
    task automatic send(input logic [29:0] w, input logic sel_n);
        chip_sel_n <= sel_n;
        wt(6);
        for (int i = 29; i >= 0; i--) begin
            ser_din <= w[i];
            ser_clk <= 1'b1;
            wt(6);
            ser_clk <= 1'b0;
            wt(6);
        end
        // clock parked low, released data inverted
        chip_sel_n <= 1'b1;
        ser_din <= ~w[0];
        wt(6);
    endtask : send
    // load pulse wide enough for the synchroniser
    task automatic load();
        ser_load <= 1'b1;
        wt(8);
        ser_load <= 1'b0;
        wt(8);
    endtask : load
    // select toggled twice with the clock high
    task automatic cs_pulse(input logic d);
        ser_din <= d;
        ser_clk <= 1'b1;
        wt(6);
        chip_sel_n <= 1'b0;
        wt(6);
        chip_sel_n <= 1'b1;
        wt(6);
        ser_clk <= 1'b0;
        ser_din <= ~d;
        wt(6);
    endtask : cs_pulse
endmodule : lcd_host_model
`default_nettype wire

// File: test/lcd_seg_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module lcd_seg_asserts (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // serial pins
    input wire logic chip_sel_n,
    input wire logic ser_clk,
    input wire logic ser_load,
    input wire logic ser_dout,
    // oscillator and display
    input wire logic osc_clock_pin,
    input wire logic osc_option_pin,
    input wire logic [lcd_seg_pkg::SEG_COUNT-1:0] segment,
    input wire logic backplane
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic clk_q, cs_q, bp_q, osc_q;
    logic [7:0] t_rise, t_cs, t_ld, t_bp, rises;
    logic [8:0] t_hi;
    // saturating ages of pin events, plus a count of osc rises since the last backplane move; reset counts as fresh so nothing fires early
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            {clk_q, cs_q, bp_q, osc_q, t_rise, t_cs, t_ld, t_bp, rises, t_hi} <= '0;
        end else begin
            {clk_q, cs_q, bp_q, osc_q} <= {ser_clk, chip_sel_n, backplane, osc_clock_pin};
            t_rise <= (ser_clk && !clk_q) ? 8'h00 : t_rise + 8'(t_rise != 8'hff);
            t_cs <= (chip_sel_n != cs_q) ? 8'h00 : t_cs + 8'(t_cs != 8'hff);
            t_ld <= ser_load ? 8'h00 : t_ld + 8'(t_ld != 8'hff);
            t_bp <= (backplane != bp_q) ? 8'h00 : t_bp + 8'(t_bp != 8'hff);
            t_hi <= osc_clock_pin ? t_hi + 9'(t_hi != 9'h1ff) : 9'h000;
            rises <= (!osc_option_pin || backplane != bp_q) ? 8'h00 : rises + 8'(osc_clock_pin && !osc_q);
        end
    end
    property p_div_exact; $changed(backplane) && osc_option_pin && t_hi < 9'h0c8 |-> rises == 8'h80; endproperty
    a_div_exact: assert property (p_div_exact) else $error("divide count");
    property p_div_bound; osc_option_pin && t_hi < 9'h0c8 |-> rises <= 8'h80; endproperty
    a_div_bound: assert property (p_div_bound) else $error("divide overrun");
    sequence s_ext_steady; ($stable(osc_clock_pin) && !osc_option_pin)[*5]; endsequence
    property p_ext; s_ext_steady ##0 t_hi < 9'h0c8 |-> backplane == osc_clock_pin; endproperty
    a_ext: assert property (p_ext) else $error("slave backplane");
    property p_static; t_hi > 9'h107 |-> !backplane; endproperty
    a_static: assert property (p_static) else $error("static backplane");
    property p_dout; $changed(ser_dout) |-> t_rise < 8'h07 || t_cs < 8'h09; endproperty
    a_dout: assert property (p_dout) else $error("serial output moved");
    property p_hold; $changed(segment) && $stable(backplane) && t_bp > 8'h03 |-> t_ld < 8'h07; endproperty
    a_hold: assert property (p_hold) else $error("segments moved");
    sequence s_bp_edge; $changed(backplane) && t_ld > 8'h0c && t_bp > 8'h06; endsequence
    property p_invert; s_bp_edge |-> ##[0:2] (segment == ~$past(segment, 3)); endproperty
    a_invert: assert property (p_invert) else $error("segments not inverted");
    property p_off; $rose(rst_n) |-> segment == {lcd_seg_pkg::SEG_COUNT{backplane}}; endproperty
    a_off: assert property (p_off) else $error("segments after reset");
endmodule : lcd_seg_asserts
bind lcd_seg_driver lcd_seg_asserts asserts_u (.sys_clk, .rst_n, .chip_sel_n, .ser_clk, .ser_load,
    .ser_dout, .osc_clock_pin, .osc_option_pin, .segment, .backplane);
`default_nettype wire

// File: test/test_serial_lcd_segment_driver.sv
`timescale 1ns/10ps
`default_nettype none
module test_serial_lcd_segment_driver;
    `define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
        $display("ERROR %0t got %h exp %h", $time, (a), (b)); end end
    typedef struct packed {logic [29:0] w; logic [29:0] seg; logic dout;} row_t;
    row_t rows [4] = '{'{30'h3fff_ffff, 30'h3fff_ffff, 1'b0}, '{30'h2aaa_aaaa, 30'h2aaa_aaaa, 1'b1},
        '{30'h1555_5555, 30'h1555_5555, 1'b0}, '{30'h0000_0001, 30'h0000_0001, 1'b1}};
    logic sys_clk, chip_sel_n, ser_clk, ser_load, ser_din, ser_dout, backplane;
    logic rst_n = 1'b0, osc_option_pin = 1'b1, osc_clock_pin = 1'b0, osc_run = 1'b0, osc_hold = 1'b0;
    logic [2:0] osc_cnt = 3'h0;
    logic [29:0] segment, prev = 30'h0;
    int err_count = 0, n_checks = 0, cyc = 0, n;
    lcd_host_model host_u (.sys_clk, .chip_sel_n, .ser_clk, .ser_load, .ser_din);
    lcd_seg_driver dut_u (.sys_clk, .rst_n, .chip_sel_n, .ser_clk, .ser_load, .ser_din, .ser_dout,
        .osc_clock_pin, .osc_option_pin, .segment, .backplane);
    // 250 MHz system clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // oscillator pin with an 8 cycle period, plus the hang ceiling
    always @(posedge sys_clk) begin
        osc_cnt <= osc_cnt + 3'h1;
        osc_clock_pin <= osc_run ? osc_cnt[2] : osc_hold;
        cyc++;
        if (cyc == 12000) begin
            err_count++;
            report_and_stop();
        end
    end
    // cycles to the next backplane move, sampled off the active edge
    task automatic wait_bp(output int k);
        logic b;
        b = backplane;
        k = 0;
        do begin @(negedge sys_clk); k++; end while (backplane === b && k < 1200);
    endtask : wait_bp
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        `CHK({segment, backplane, ser_dout}, 32'h0)
        // frames: old segments hold until load, cascade bit, new segments
        foreach (rows[i]) begin
            host_u.send(rows[i].w, 1'b0);
            `CHK(segment, prev)
            `CHK(ser_dout, rows[i].dout)
            host_u.load();
            `CHK(segment, rows[i].seg)
            prev = rows[i].seg;
        end
        // deselected clocking, then select toggled with the clock high
        host_u.send(30'h2aaa_aaaa, 1'b1);
        host_u.load();
        `CHK(segment, prev)
        host_u.cs_pulse(1'b1);
        host_u.load();
        prev = {prev[27:0], 2'b11};
        `CHK(segment, prev)
        // internal oscillator: inversion, then two full half periods
        osc_run <= 1'b1;
        wait_bp(n);
        repeat (4) @(negedge sys_clk);
        `CHK(segment, ~prev)
        wait_bp(n);
        wait_bp(n);
        `CHK(n, 1024)
        wait_bp(n);
        `CHK(n, 1024)
        // pin held high stops the oscillator
        @(posedge sys_clk);
        osc_run <= 1'b0;
        osc_hold <= 1'b1;
        repeat (300) @(posedge sys_clk);
        `CHK({segment, backplane}, {prev, 1'b0})
        // slave mode follows the pin level
        osc_option_pin <= 1'b0;
        for (int j = 0; j < 4; j++) begin
            osc_hold <= j[0];
            repeat (12) @(posedge sys_clk);
            `CHK({backplane, segment}, {j[0], prev ^ {30{j[0]}}})
        end
        report_and_stop();
    end
endmodule : test_serial_lcd_segment_driver
`default_nettype wire
